// ===== core/serial_map.svh
// register offsets, field positions, reset values and bit timing counts
// assumes the oscillator is the block clock CLK (100 MHz)
// Function
// - transmit and receive paths run concurrently in modes 1-3; mode 0 shares one shifter
// - second frame received while first unread
// - four modes, oscillator or divisor timing
// - mode 0: eight bits LSB first, clock/6
// - mode 1: start, eight data, stop framing
// - modes 2,3: eleven bits with ninth bit
// - mode 2 rate is osc/32 or osc/64
// - mode 3 equals mode 2 except rate
// - buffer write starts a transmission
// - mode 0 receive: flag clear, enable set
// - modes 1-3 receive on start bit
// - done flags set, interrupt and pollable
// - mode 1 multiprocessor checks stop bit
// - buffer write and read hit separate registers
// - mode select encoding 00,01,10,11
`ifndef SERIAL_MAP_SVH
`define SERIAL_MAP_SVH
// register indices; byte address is four times the index
`define SP_IDX_CTRL   8'h98
`define SP_IDX_BUF    8'h99
`define SP_IDX_STAT   8'h9a
`define SP_IDX_MASK   8'h9b
`define SP_IDX_BAUD   8'h9c
// control register fields
`define SP_CB_MODE_HI 7
`define SP_CB_MODE_LO 6
`define SP_CB_MPE     5
`define SP_CB_REN     4
`define SP_CB_TB8     3
`define SP_CB_RB8     2
`define SP_CB_TI      1
`define SP_CB_RI      0
// status and mask fields
`define SP_SB_RX      0
`define SP_SB_TX      1
`define SP_SB_OVR     2
// baud register fields
`define SP_BB_FAST    16
// reset values
`define SP_DIV_RST    16'h0364
// timing counts in clock cycles per bit
`define SP_M0_CYC     16'h0006
`define SP_M0_HALF    16'h0003
`define SP_M2_SLOW    16'h0040
`define SP_M2_FAST    16'h0020
`define SP_ONE        16'h0001
// bit indices
`define SP_BIT_M0_LAST 4'h7
`define SP_BIT_T8_LAST 4'h7
`define SP_BIT_T9_LAST 4'h8
`define SP_BIT_R8_LAST 4'h8
`define SP_BIT_R9_LAST 4'h9
`endif

// ===== core/serial_pkg.sv
// types of the serial port: modes, states and the state record
// assumes serial_map.svh for numeric constants
package serial_pkg;
  typedef enum logic [1:0] {
    M_SHIFT = 2'b00, M_UART8 = 2'b01, M_UART9F = 2'b10, M_UART9V = 2'b11
  } mode_t;
  typedef enum logic [1:0] {
    T_IDLE = 2'b00, T_START = 2'b01, T_DATA = 2'b11, T_STOP = 2'b10
  } tx_st_t;
  typedef enum logic [1:0] {
    R_IDLE = 2'b00, R_START = 2'b01, R_DATA = 2'b11, R_STOP = 2'b10
  } rx_st_t;
  typedef struct packed {
    mode_t        mode;
    logic         mpe;
    logic         ren;
    logic         tb8;
    logic         rb8;
    logic         ti;
    logic         ri;
    logic         ovr;
    logic [2:0]   mask;
    logic         fast;
    logic [15:0]  div;
    logic [7:0]   rx_buf;
    tx_st_t       tx_st;
    logic [15:0]  tx_cnt;
    logic [3:0]   tx_bit;
    logic [8:0]   tx_sh;
    logic         m0rx;
    logic         sclk;
    logic         txd;
    logic         txo;
    logic         rxo;
    logic         rxoe;
    rx_st_t       rx_st;
    logic [15:0]  rx_cnt;
    logic [3:0]   rx_bit;
    logic [9:0]   rx_sh;
    logic         rx_s1;
    logic         rx_s2;
    logic         rx_d;
    logic         ack;
    logic [31:0]  rdata;
  } state_t;
endpackage

// ===== core/serial_port_zero_uart.sv
// serial port 0: shift-register mode and three UART modes, Avalon-MM slave
// assumes a 100 MHz CLK used as oscillator; the rx pin is two-way
`timescale 1ns/1ns
`include "serial_map.svh"
module serial_port_zero_uart (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [9:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  input  wire logic [3:0]  BYTEENABLE,
  output      logic [31:0] READDATA,
  output      logic        WAITREQUEST,
  output      logic        IRQ,
  input  wire logic        SERIAL_RX_PIN_I,
  output      logic        SERIAL_RX_PIN_O,
  output      logic        SERIAL_RX_PIN_OE,
  output      logic        SERIAL_TX_PIN
);

  serial_pkg::state_t s_r;    // all registered state
  serial_pkg::state_t s_nxt;  // next state
  logic [7:0]  idx;           // register index from byte address
  logic        wr_hit;        // write takes effect this edge
  logic [15:0] bitp;          // uart cycles per bit
  logic        fall;          // falling edge on synced rx line
  logic        ev_rx;         // frame received and stored
  logic        ev_tx;         // frame sent
  logic        ev_ovr;        // frame dropped, buffer unread
  logic        rx_ok;         // frame passes multiprocessor filter
  logic        rx_nin;        // received ninth bit or stop bit
  logic [7:0]  rx_dat;        // received data byte
  logic [3:0]  t_last;        // last tx data bit index
  logic [3:0]  r_last;        // last rx sample index
  logic [2:0]  stat;          // sticky status view

  // bus handshake: one wait cycle, then answer
  assign WAITREQUEST = (READ | WRITE) & ~s_r.ack;
  assign READDATA    = s_r.rdata;
  assign stat        = {s_r.ovr, s_r.ti, s_r.ri};
  assign IRQ         = |(stat & s_r.mask);
  // pins from flops
  assign SERIAL_RX_PIN_O  = s_r.rxo;
  assign SERIAL_RX_PIN_OE = s_r.rxoe;
  assign SERIAL_TX_PIN    = s_r.txo;

  // next-state logic of the whole port
  always_comb begin
    s_nxt  = s_r;
    ev_rx  = 1'b0;
    ev_tx  = 1'b0;
    ev_ovr = 1'b0;
    rx_ok  = 1'b0;
    rx_nin = 1'b0;
    rx_dat = 8'h00;
    idx    = ADDRESS[9:2];
    wr_hit = WRITE & s_r.ack;
    // two-flop synchroniser, then an edge stage
    s_nxt.rx_s1 = SERIAL_RX_PIN_I;
    s_nxt.rx_s2 = s_r.rx_s1;
    s_nxt.rx_d  = s_r.rx_s2;
    fall = s_r.rx_d & ~s_r.rx_s2;
    // bit period: mode 2 fixed, modes 1 and 3 from the divisor
    if (s_r.mode == serial_pkg::M_UART9F) begin
      bitp = s_r.fast ? `SP_M2_FAST : `SP_M2_SLOW;
    end else begin
      bitp = s_r.div;
    end
    // frame length depends on the mode
    if (s_r.mode == serial_pkg::M_UART8) begin
      t_last = `SP_BIT_T8_LAST;
      r_last = `SP_BIT_R8_LAST;
    end else begin
      t_last = `SP_BIT_T9_LAST;
      r_last = `SP_BIT_R9_LAST;
    end

    // bus: ack after one wait cycle
    s_nxt.ack   = (READ | WRITE) & ~s_r.ack;
    s_nxt.rdata = 32'h0000_0000;
    // read data captured in the wait cycle
    if (READ & ~s_r.ack) begin
      unique case (idx)
        `SP_IDX_CTRL: begin
          s_nxt.rdata[`SP_CB_MODE_HI:`SP_CB_MODE_LO] = s_r.mode;
          s_nxt.rdata[`SP_CB_MPE] = s_r.mpe;
          s_nxt.rdata[`SP_CB_REN] = s_r.ren;
          s_nxt.rdata[`SP_CB_TB8] = s_r.tb8;
          s_nxt.rdata[`SP_CB_RB8] = s_r.rb8;
          s_nxt.rdata[`SP_CB_TI]  = s_r.ti;
          s_nxt.rdata[`SP_CB_RI]  = s_r.ri;
        end
        `SP_IDX_BUF: begin
          s_nxt.rdata[7:0] = s_r.rx_buf;
        end
        `SP_IDX_STAT: begin
          s_nxt.rdata[2:0] = stat;
        end
        `SP_IDX_MASK: begin
          s_nxt.rdata[2:0] = s_r.mask;
        end
        `SP_IDX_BAUD: begin
          s_nxt.rdata[15:0] = s_r.div;
          s_nxt.rdata[`SP_BB_FAST] = s_r.fast;
        end
        default: begin
          s_nxt.rdata = 32'h0000_0000;  // unmapped reads zero
        end
      endcase
    end

    // register writes; flag clears here, hardware sets later win
    if (wr_hit) begin
      unique case (idx)
        `SP_IDX_CTRL: begin
          if (BYTEENABLE[0]) begin
            s_nxt.mode = serial_pkg::mode_t'(
              WRITEDATA[`SP_CB_MODE_HI:`SP_CB_MODE_LO]);
            s_nxt.mpe = WRITEDATA[`SP_CB_MPE];
            s_nxt.ren = WRITEDATA[`SP_CB_REN];
            s_nxt.tb8 = WRITEDATA[`SP_CB_TB8];
            s_nxt.rb8 = WRITEDATA[`SP_CB_RB8];
            // writing zero clears a done flag
            if (!WRITEDATA[`SP_CB_TI]) begin
              s_nxt.ti = 1'b0;
            end
            if (!WRITEDATA[`SP_CB_RI]) begin
              s_nxt.ri = 1'b0;
            end
          end
        end
        `SP_IDX_STAT: begin
          // write one to clear
          if (BYTEENABLE[0]) begin
            if (WRITEDATA[`SP_SB_RX]) begin
              s_nxt.ri = 1'b0;
            end
            if (WRITEDATA[`SP_SB_TX]) begin
              s_nxt.ti = 1'b0;
            end
            if (WRITEDATA[`SP_SB_OVR]) begin
              s_nxt.ovr = 1'b0;
            end
          end
        end
        `SP_IDX_MASK: begin
          if (BYTEENABLE[0]) begin
            s_nxt.mask = WRITEDATA[2:0];
          end
        end
        `SP_IDX_BAUD: begin
          if (BYTEENABLE[0]) begin
            s_nxt.div[7:0] = WRITEDATA[7:0];
          end
          if (BYTEENABLE[1]) begin
            s_nxt.div[15:8] = WRITEDATA[15:8];
          end
          if (BYTEENABLE[2]) begin
            s_nxt.fast = WRITEDATA[`SP_BB_FAST];
          end
        end
        default: begin
          s_nxt.mask = s_nxt.mask;  // buffer handled below, unmapped writes ignored
        end
      endcase
    end

    // transmit path, also the mode 0 shifter
    unique case (s_r.tx_st)
      serial_pkg::T_IDLE: begin
        // mode 0 receive starts with flag clear and enable set
        if (s_r.mode == serial_pkg::M_SHIFT && !s_r.ri && s_r.ren) begin
          s_nxt.m0rx   = 1'b1;
          s_nxt.tx_st  = serial_pkg::T_DATA;
          s_nxt.tx_cnt = 16'(`SP_M0_CYC - `SP_ONE);
          s_nxt.tx_bit = 4'h0;
          s_nxt.sclk   = 1'b0;
          s_nxt.rxoe   = 1'b0;
        end
      end
      serial_pkg::T_START: begin
        s_nxt.tx_cnt = 16'(s_r.tx_cnt - `SP_ONE);
        if (s_r.tx_cnt == 16'h0000) begin
          s_nxt.tx_st  = serial_pkg::T_DATA;
          s_nxt.txd    = s_r.tx_sh[0];  // LSB first
          s_nxt.tx_cnt = 16'(bitp - `SP_ONE);
          s_nxt.tx_bit = 4'h0;
        end
      end
      serial_pkg::T_DATA: begin
        s_nxt.tx_cnt = 16'(s_r.tx_cnt - `SP_ONE);
        if (s_r.mode == serial_pkg::M_SHIFT) begin
          // clock rises mid-bit; receive samples there
          if (s_r.tx_cnt == `SP_M0_HALF) begin
            s_nxt.sclk = 1'b1;
            if (s_r.m0rx) begin
              s_nxt.tx_sh[7:0] = {s_r.rx_s2, s_r.tx_sh[7:1]};
            end
          end
          if (s_r.tx_cnt == 16'h0000) begin
            s_nxt.tx_cnt = 16'(`SP_M0_CYC - `SP_ONE);
            if (s_r.tx_bit == `SP_BIT_M0_LAST) begin
              s_nxt.tx_st = serial_pkg::T_IDLE;
              s_nxt.rxoe  = 1'b0;
              s_nxt.m0rx  = 1'b0;
              if (s_r.m0rx) begin
                s_nxt.rx_buf = s_r.tx_sh[7:0];
                ev_rx = 1'b1;
              end else begin
                ev_tx = 1'b1;
              end
            end else begin
              s_nxt.sclk   = 1'b0;
              s_nxt.tx_bit = 4'(s_r.tx_bit + 4'h1);
              if (!s_r.m0rx) begin
                s_nxt.tx_sh = {1'b0, s_r.tx_sh[8:1]};
                s_nxt.rxo   = s_r.tx_sh[1];
              end
            end
          end
        end else if (s_r.tx_cnt == 16'h0000) begin
          s_nxt.tx_cnt = 16'(bitp - `SP_ONE);
          if (s_r.tx_bit == t_last) begin
            s_nxt.tx_st = serial_pkg::T_STOP;
            s_nxt.txd   = 1'b1;
          end else begin
            s_nxt.tx_sh  = {1'b0, s_r.tx_sh[8:1]};
            s_nxt.txd    = s_r.tx_sh[1];  // ninth bit after data
            s_nxt.tx_bit = 4'(s_r.tx_bit + 4'h1);
          end
        end
      end
      serial_pkg::T_STOP: begin
        s_nxt.tx_cnt = 16'(s_r.tx_cnt - `SP_ONE);
        if (s_r.tx_cnt == 16'h0000) begin
          s_nxt.tx_st = serial_pkg::T_IDLE;
          ev_tx = 1'b1;
        end
      end
    endcase

    // buffer write loads the transmit shifter and starts it
    if (wr_hit && idx == `SP_IDX_BUF && BYTEENABLE[0]) begin
      s_nxt.tx_sh  = {s_r.tb8, WRITEDATA[7:0]};
      s_nxt.tx_bit = 4'h0;
      if (s_r.mode == serial_pkg::M_SHIFT) begin
        s_nxt.tx_st  = serial_pkg::T_DATA;
        s_nxt.m0rx   = 1'b0;
        s_nxt.sclk   = 1'b0;
        s_nxt.rxoe   = 1'b1;
        s_nxt.rxo    = WRITEDATA[0];
        s_nxt.tx_cnt = 16'(`SP_M0_CYC - `SP_ONE);
      end else begin
        s_nxt.tx_st  = serial_pkg::T_START;
        s_nxt.txd    = 1'b0;
        s_nxt.tx_cnt = 16'(bitp - `SP_ONE);
      end
    end
    // mode 0 drives the shift clock on the tx pin
    if (s_nxt.mode == serial_pkg::M_SHIFT) begin
      s_nxt.txo = s_nxt.sclk;
    end else begin
      s_nxt.txo = s_nxt.txd;
    end

    // receive path of the uart modes, independent of transmit
    unique case (s_r.rx_st)
      serial_pkg::R_IDLE: begin
        if (s_r.mode != serial_pkg::M_SHIFT && s_r.ren && fall) begin
          s_nxt.rx_st  = serial_pkg::R_START;
          s_nxt.rx_cnt = 16'((bitp >> 1) - `SP_ONE);
        end
      end
      serial_pkg::R_START: begin
        s_nxt.rx_cnt = 16'(s_r.rx_cnt - `SP_ONE);
        if (s_r.rx_cnt == 16'h0000) begin
          // glitch rejection at the start bit centre
          if (!s_r.rx_s2) begin
            s_nxt.rx_st  = serial_pkg::R_DATA;
            s_nxt.rx_cnt = 16'(bitp - `SP_ONE);
            s_nxt.rx_bit = 4'h0;
          end else begin
            s_nxt.rx_st = serial_pkg::R_IDLE;
          end
        end
      end
      serial_pkg::R_DATA: begin
        s_nxt.rx_cnt = 16'(s_r.rx_cnt - `SP_ONE);
        if (s_r.rx_cnt == 16'h0000) begin
          s_nxt.rx_sh  = {s_r.rx_s2, s_r.rx_sh[9:1]};
          s_nxt.rx_cnt = 16'(bitp - `SP_ONE);
          s_nxt.rx_bit = 4'(s_r.rx_bit + 4'h1);
          if (s_r.rx_bit == r_last) begin
            s_nxt.rx_st = serial_pkg::R_STOP;
          end
        end
      end
      serial_pkg::R_STOP: begin
        // commit cycle: filter, then store or drop
        s_nxt.rx_st = serial_pkg::R_IDLE;
        if (s_r.mode == serial_pkg::M_UART8) begin
          rx_dat = s_r.rx_sh[8:1];
          rx_nin = s_r.rx_sh[9];  // stop bit
          rx_ok  = !s_r.mpe || s_r.rx_sh[9];
        end else begin
          rx_dat = s_r.rx_sh[7:0];
          rx_nin = s_r.rx_sh[8];  // ninth bit, stop ignored
          rx_ok  = !s_r.mpe || s_r.rx_sh[8];
        end
        if (rx_ok) begin
          if (s_r.ri) begin
            ev_ovr = 1'b1;
          end else begin
            s_nxt.rx_buf = rx_dat;
            s_nxt.rb8    = rx_nin;
            ev_rx = 1'b1;
          end
        end
      end
    endcase

    // hardware sets win over software clears, no auto clear
    if (ev_rx) begin
      s_nxt.ri = 1'b1;
    end
    if (ev_tx) begin
      s_nxt.ti = 1'b1;
    end
    if (ev_ovr) begin
      s_nxt.ovr = 1'b1;
    end
  end

  // state register with asynchronous reset
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s_r        <= '0;
      s_r.mode   <= serial_pkg::M_SHIFT;
      s_r.tx_st  <= serial_pkg::T_IDLE;
      s_r.rx_st  <= serial_pkg::R_IDLE;
      s_r.div    <= `SP_DIV_RST;
      s_r.sclk   <= 1'b1;
      s_r.txd    <= 1'b1;
      s_r.txo    <= 1'b1;
      s_r.rxo    <= 1'b1;
      s_r.rx_s1  <= 1'b1;
      s_r.rx_s2  <= 1'b1;
      s_r.rx_d   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// ===== testbench/serial_partner.sv
// far side: remote uart or external shift register on the serial pins
// assumes the bench calls its tasks; the rx wire has a pull-up
`timescale 1ns/1ns
module serial_partner (
  input  wire logic clk,
  input  wire logic tx_pin,
  input  wire logic dut_o,
  input  wire logic dut_oe,
  output      logic line
);
  logic drv = 1'b1; // far drive, idle high
  // two-way wire: device drive wins while enabled
  assign line = dut_oe ? dut_o : drv;
  // uart frame out, LSB first, p cycles a bit
  task automatic send(input logic [10:0] bits, input int n, input int p);
    for (int i = 0; i < n; i++) begin
      drv <= bits[i];
      repeat (p) @(posedge clk);
    end
    drv <= 1'b1;
  endtask
  // sample a uart frame at mid-bit
  task automatic grab(input int n, input int p, output logic [10:0] bits);
    bits = 11'h000;
    @(negedge tx_pin);
    repeat (p / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = tx_pin;
      repeat (p) @(posedge clk);
    end
  endtask
  // shift register: next bit on each clock fall
  task automatic m0_send(input logic [7:0] b);
    drv <= b[0];
    for (int i = 0; i < 8; i++) begin
      @(negedge tx_pin);
      drv <= b[i];
    end
    @(posedge tx_pin);
    repeat (3) @(posedge clk);
    drv <= 1'b1;
  endtask
endmodule

// ===== testbench/serial_port_zero_uart_chk.sv
// checker for the register bus and mode 0 pins of serial port 0
// assumes it is bound onto serial_port_zero_uart
`timescale 1ns/1ns
module serial_port_zero_uart_chk (
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic [9:0]  ADDRESS,
  input wire logic        READ,
  input wire logic        WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0]  BYTEENABLE,
  input wire logic [31:0] READDATA,
  input wire logic        WAITREQUEST,
  input wire logic        IRQ,
  input wire logic        SERIAL_RX_PIN_I,
  input wire logic        SERIAL_RX_PIN_O,
  input wire logic        SERIAL_RX_PIN_OE,
  input wire logic        SERIAL_TX_PIN
);
  logic       prev_clk_r; // shift clock one cycle ago
  logic [3:0] falls_r;    // shift clock falls in this transfer
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // count falls of the shift clock while the rx pin is driven
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      prev_clk_r <= 1'b1;
      falls_r    <= 4'h0;
    end else begin
      prev_clk_r <= SERIAL_TX_PIN;
      if (!SERIAL_RX_PIN_OE) falls_r <= 4'h0;
      else if (prev_clk_r && !SERIAL_TX_PIN) falls_r <= falls_r + 4'h1;
    end
  end
  wait_one_a: assert property ((READ || WRITE) && WAITREQUEST |=>
    !WAITREQUEST) else $error("bus wait is not one cycle");
  idle_free_a: assert property (!(READ || WRITE) |-> !WAITREQUEST)
    else $error("wait raised without request");
  rdata_zero_a: assert property (WAITREQUEST || !READ |->
    READDATA == 32'h0) else $error("read data outside answer");
  shift_low_a: assert property ($fell(SERIAL_TX_PIN) &&
    SERIAL_RX_PIN_OE |-> !SERIAL_TX_PIN [*3] ##1 SERIAL_TX_PIN)
    else $error("shift clock low phase not 3");
  shift_high_a: assert property ($rose(SERIAL_TX_PIN) &&
    SERIAL_RX_PIN_OE |-> SERIAL_TX_PIN [*3])
    else $error("shift clock high phase short");
  data_hold_a: assert property (SERIAL_RX_PIN_OE &&
    $past(SERIAL_RX_PIN_OE) && SERIAL_TX_PIN && $past(SERIAL_TX_PIN)
    |-> $stable(SERIAL_RX_PIN_O)) else $error("data moved in clock high");
  m0_bits_a: assert property (falls_r <= 4'h8)
    else $error("more than eight shift clocks");
  oe_end_a: assert property ($fell(SERIAL_RX_PIN_OE) |->
    SERIAL_TX_PIN && falls_r == 4'h8) else $error("bad end of shift");
  irq_fall_a: assert property ($fell(IRQ) |->
    $past(WRITE && !WAITREQUEST)) else $error("irq dropped by itself");
  cover property ($fell(SERIAL_RX_PIN_OE));
  cover property ($rose(IRQ));
  cover property (READ && !WAITREQUEST);
endmodule
bind serial_port_zero_uart serial_port_zero_uart_chk u_chk (
  .CLK(CLK), .NRST(NRST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
  .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
  .WAITREQUEST(WAITREQUEST), .IRQ(IRQ), .SERIAL_RX_PIN_I(SERIAL_RX_PIN_I),
  .SERIAL_RX_PIN_O(SERIAL_RX_PIN_O), .SERIAL_RX_PIN_OE(SERIAL_RX_PIN_OE),
  .SERIAL_TX_PIN(SERIAL_TX_PIN));

// ===== testbench/test_serial_port_zero_uart.sv
// self-checking bench for serial port 0 with a far-side model
// assumes serial_map.svh offsets and the one-wait-cycle bus
`timescale 1ns/1ns
`include "serial_map.svh"
module test_serial_port_zero_uart;
  logic        CLK = 1'b0;
  logic        NRST = 1'b0;
  logic [9:0]  ADDRESS = 10'h000;
  logic        READ = 1'b0;
  logic        WRITE = 1'b0;
  logic [31:0] WRITEDATA = 32'h0;
  logic [3:0]  BYTEENABLE = 4'hf;
  logic [31:0] READDATA, q;
  logic [10:0] got;
  logic        WAITREQUEST, IRQ, RX_LINE, RX_O, RX_OE, TX_PIN;
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc = 0;
  logic        wait_s;   // waitrequest as settled in mid-cycle
  logic [31:0] rdata_s;  // read data as settled in mid-cycle
  serial_port_zero_uart u_dut (
    .CLK(CLK), .NRST(NRST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .IRQ(IRQ), .SERIAL_RX_PIN_I(RX_LINE),
    .SERIAL_RX_PIN_O(RX_O), .SERIAL_RX_PIN_OE(RX_OE),
    .SERIAL_TX_PIN(TX_PIN));
  serial_partner u_far (.clk(CLK), .tx_pin(TX_PIN), .dut_o(RX_O),
    .dut_oe(RX_OE), .line(RX_LINE));
  initial forever #5 CLK = ~CLK;
  // bus answer settles by the falling edge and stands to the rising one;
  // reading it at the rising edge itself would race the design's flops
  always @(negedge CLK) begin
    wait_s  <= WAITREQUEST;
    rdata_s <= READDATA;
  end
  // hang guard
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one avalon cycle, held until wait is low
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge CLK);
    WRITE <= w;
    READ <= !w;
    ADDRESS <= {i, 2'b00};
    WRITEDATA <= d;
    @(posedge CLK);
    while (wait_s !== 1'b0) @(posedge CLK);
    q = rdata_s;
    READ <= 1'b0;
    WRITE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rd(input logic [7:0] i);
    bus(1'b0, i, 32'h0);
  endtask
  // control word; ones on the flags leave them alone
  function automatic logic [31:0] ctl(logic [1:0] m, logic mp, logic re,
                                      logic t8);
    return {24'h0, m, mp, re, t8, 3'b011};
  endfunction
  // frame LSB first: start, data, ninth if nb9, stop
  function automatic logic [10:0] frm(logic [7:0] d, logic n9, logic sp,
                                      logic nb9);
    return nb9 ? {sp, n9, d, 1'b0} : {1'b0, sp, d, 1'b0};
  endfunction
  task automatic until_set(input int b);
    int n = 0;
    do begin
      rd(`SP_IDX_STAT);
      n++;
    end while (q[b] !== 1'b1 && n < 400);
    chk(q[b], 1'b1);
  endtask
  task automatic t_reset();
    chk(IRQ, 1'b0);
    chk(TX_PIN, 1'b1);
    rd(`SP_IDX_CTRL);
    chk(q, 32'h0);
    rd(`SP_IDX_BAUD);
    chk(q, {16'h0, `SP_DIV_RST});
    rd(8'h9f);
    chk(q, 32'h0);
  endtask
  task automatic t_uart1();
    wr(`SP_IDX_BAUD, 32'h10);
    wr(`SP_IDX_MASK, 32'h3);
    wr(`SP_IDX_CTRL, ctl(2'b01, 1'b0, 1'b1, 1'b0));
    fork
      u_far.grab(10, 16, got);
      wr(`SP_IDX_BUF, 32'ha5);
      u_far.send(frm(8'h3c, 1'b0, 1'b1, 1'b0), 10, 16);
    join
    chk(got, frm(8'ha5, 1'b0, 1'b1, 1'b0));
    until_set(`SP_SB_TX);
    rd(`SP_IDX_BUF);
    chk(q, 32'h3c);
    rd(`SP_IDX_CTRL);
    chk(q[2:0], 3'h7);
    chk(IRQ, 1'b1);
    wr(`SP_IDX_MASK, 32'h0);
    @(posedge CLK);
    chk(IRQ, 1'b0);
    wr(`SP_IDX_MASK, 32'h3);
  endtask
  task automatic t_overrun();
    u_far.send(frm(8'h55, 1'b0, 1'b1, 1'b0), 10, 16);
    repeat (40) @(posedge CLK);
    rd(`SP_IDX_BUF);
    chk(q, 32'h3c);
    rd(`SP_IDX_STAT);
    chk(q[2:0], 3'h7);
    wr(`SP_IDX_STAT, 32'h7);
    @(posedge CLK);
    chk(IRQ, 1'b0);
    rd(`SP_IDX_CTRL);
    chk(q[1:0], 2'h0);
  endtask
  task automatic t_mpe1();
    wr(`SP_IDX_CTRL, ctl(2'b01, 1'b1, 1'b1, 1'b0));
    u_far.send(frm(8'h77, 1'b0, 1'b0, 1'b0), 10, 16);
    repeat (48) @(posedge CLK);
    rd(`SP_IDX_STAT);
    chk(q[0], 1'b0);
    u_far.send(frm(8'h78, 1'b0, 1'b1, 1'b0), 10, 16);
    until_set(`SP_SB_RX);
    rd(`SP_IDX_BUF);
    chk(q, 32'h78);
    wr(`SP_IDX_STAT, 32'h7);
  endtask
  task automatic t_mode2();
    int p;
    for (int f = 1; f >= 0; f--) begin
      p = f ? 32 : 64;
      wr(`SP_IDX_BAUD, {15'h0, f[0], 16'h10});
      wr(`SP_IDX_CTRL, ctl(2'b10, 1'b0, 1'b1, 1'b1));
      fork
        u_far.grab(11, p, got);
        wr(`SP_IDX_BUF, 32'h96);
        u_far.send(frm(8'h69, 1'b1, 1'b1, 1'b1), 11, p);
      join
      chk(got, frm(8'h96, 1'b1, 1'b1, 1'b1));
      until_set(`SP_SB_TX);
      rd(`SP_IDX_CTRL);
      chk(q[2:0], 3'h7);
      rd(`SP_IDX_BUF);
      chk(q, 32'h69);
      wr(`SP_IDX_STAT, 32'h7);
    end
  endtask
  task automatic t_mode3();
    wr(`SP_IDX_BAUD, 32'h10);
    wr(`SP_IDX_CTRL, ctl(2'b11, 1'b1, 1'b1, 1'b0));
    u_far.send(frm(8'h11, 1'b0, 1'b1, 1'b1), 11, 16);
    repeat (48) @(posedge CLK);
    rd(`SP_IDX_STAT);
    chk(q[0], 1'b0);
    u_far.send(frm(8'h42, 1'b1, 1'b1, 1'b1), 11, 16);
    until_set(`SP_SB_RX);
    rd(`SP_IDX_CTRL);
    chk(q[2:0], 3'h5);
    rd(`SP_IDX_BUF);
    chk(q, 32'h42);
    wr(`SP_IDX_STAT, 32'h7);
  endtask
  task automatic t_mode0();
    int t0 = 0;
    wr(`SP_IDX_CTRL, ctl(2'b00, 1'b0, 1'b0, 1'b0));
    wr(`SP_IDX_BUF, 32'hc3);
    for (int i = 0; i < 8; i++) begin
      @(posedge TX_PIN);
      got[i] = RX_O;
      chk(RX_OE, 1'b1);
      if (i > 0) chk(int'($time) - t0, 32'h3c);
      t0 = int'($time);
    end
    chk(got[7:0], 8'hc3);
    until_set(`SP_SB_TX);
    fork
      u_far.m0_send(8'h5a);
      wr(`SP_IDX_CTRL, ctl(2'b00, 1'b0, 1'b1, 1'b0));
    join
    until_set(`SP_SB_RX);
    rd(`SP_IDX_BUF);
    chk(q, 32'h5a);
    wr(`SP_IDX_CTRL, 32'h0);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    NRST <= 1'b1;
    t_reset();
    t_uart1();
    t_overrun();
    t_mpe1();
    t_mode2();
    t_mode3();
    t_mode0();
    complete_run();
  end
endmodule
